// [ipc_pkg.sv]
package ipc_pkg;

    // ==================================================================
    // sizes and source numbering
    localparam int          NSRC      = 21;
    localparam int          NFLAG     = 25;
    localparam int          NLVL      = 4;
    localparam int          NTMR      = 7;
    localparam int          NPIN      = 7;
    localparam int          WDT_W     = 24;
    localparam int          RANK_TMR  = 4;
    localparam int          RANK_P4   = 11;
    localparam int          RANK_P5   = 12;
    localparam int          RANK_AD   = 13;
    localparam int          RANK_SERA = 14;
    localparam int          RANK_SRA  = 15;
    localparam int          RANK_STA  = 16;
    localparam int          RANK_CSI  = 17;
    localparam int          RANK_SERB = 18;
    localparam int          RANK_SRB  = 19;
    localparam int          RANK_STB  = 20;
    localparam logic [4:0]  SRC_NMI   = 5'h15;
    localparam logic [4:0]  SRC_WDT   = 5'h16;
    localparam logic [4:0]  SRC_OPE   = 5'h17;
    localparam logic [4:0]  SRC_BRK   = 5'h18;

    // ==================================================================
    // vector table
    localparam logic [15:0] VEC_NMI   = 16'h0002;
    localparam logic [15:0] VEC_WDT   = 16'h0004;
    localparam logic [15:0] VEC_BASE  = 16'h0006;
    localparam logic [15:0] VEC_OPE   = 16'h003C;
    localparam logic [15:0] VEC_BRK   = 16'h003E;

    // ==================================================================
    // register offsets (byte addresses)
    localparam logic [7:0]  OFF_PEND  = 8'h00;
    localparam logic [7:0]  OFF_EN    = 8'h04;
    localparam logic [7:0]  OFF_LVL0  = 8'h08;
    localparam logic [7:0]  OFF_LVL1  = 8'h0C;
    localparam logic [7:0]  OFF_MODE0 = 8'h10;
    localparam logic [7:0]  OFF_MODE1 = 8'h14;
    localparam logic [7:0]  OFF_EDGE  = 8'h18;
    localparam logic [7:0]  OFF_WDM   = 8'h1C;
    localparam logic [7:0]  OFF_PROT  = 8'h20;
    localparam logic [7:0]  OFF_STBY  = 8'h24;
    localparam logic [7:0]  OFF_WCLR  = 8'h28;
    localparam logic [7:0]  OFF_STAT  = 8'h2C;
    localparam logic [7:0]  OFF_BANK  = 8'h30;
    localparam logic [7:0]  OFF_TW    = 8'h34;

    // ==================================================================
    // field positions and values
    localparam int          EDGE_NMI  = 12;
    localparam int          EDGE_SMP  = 13;
    localparam int          WDM_EN    = 0;
    localparam int          WDM_SEL   = 1;
    localparam int          WDM_PRI   = 3;
    localparam int          PROT_OPND = 8;
    localparam int          PROT_TGT  = 16;
    localparam logic [7:0]  OPND_OK   = 8'hFF;
    localparam logic [5:0]  DIV_M1    = 6'h00;
    localparam logic [5:0]  DIV_M4    = 6'h03;
    localparam logic [5:0]  DIV_M16   = 6'h0F;
    localparam logic [5:0]  DIV_M64   = 6'h3F;

    // ==================================================================
    // types
    typedef enum logic [1:0] {IPC_VECTOR, IPC_BANK, IPC_MACRO} ipc_mode_e;
    typedef enum logic [1:0] {ST_IDLE, ST_OFFER, ST_MACRO} ipc_st_e;

    typedef struct packed {
        logic        valid;
        ipc_mode_e   mode;
        logic [4:0]  src;
        logic [15:0] vec;
        logic [2:0]  bank;
        logic [1:0]  lvl;
    } ipc_disp_s;

    typedef struct packed {
        logic [15:0] count;
        logic [15:0] cmp;
    } ipc_tmr_s;

    typedef struct packed {
        logic [NFLAG-1:0]     pend;
        logic [NSRC-1:0]      en;
        logic [NSRC-1:0][1:0] lvl;
        logic [NSRC-1:0][1:0] mode;
        logic [14:0]          edge_cfg;
        logic [3:0]           watchdog_mode_reg;
        logic [WDT_W-1:0]     wcnt;
        logic [7:0]           stby;
        logic [NLVL-1:0][2:0] bank;
        logic [NTMR-1:0]      tw;
        logic [NTMR-1:0]      teq;
        logic [NLVL-1:0]      isr;
        logic                 nmi_isr;
        ipc_st_e              st;
        ipc_disp_s            disp;
        logic [NPIN-1:0]      s1;
        logic [NPIN-1:0]      s2;
        logic [NPIN-1:0]      s3;
        logic [NPIN-1:0]      pin;
        logic [5:0]           div;
        logic [2:0]           trig;
        logic                 pready;
        logic                 pslverr;
        logic [31:0]          prdata;
    } ipc_state_s;

endpackage : ipc_pkg

// [ipc_ctrl.sv]
// Design decisions made here: the placing of the registers and register access over APB.
`timescale 1ns/10ps
// What this block does
// [R1] four software levels, nesting and arbitration
// [R2] equal levels served by fixed rank 0..20
// [R3] nested macro service never suspended
// [R4] per source mode: vector, bank, macro
// [R5] vectored: stack save, branch, restore
// [R6] bank mode: hardware bank, save, branch
// [R7] macro: fixed transfer, context untouched
// [R8] protected write operand error raises request
// [R9] 23 sources plus break and error
// [R10] watchdog overflow raises nonmaskable request
// [R11] watchdog cannot be disabled until reset
// [R12] setting picks watchdog or pin first
// [R13] nonmaskable pin on rising or falling
// [R14] pins 0-3 any edge, sampled filter
// [R15] pins 0-2 feed timer capture/count
// [R16] timer match in 8- or 16-bit width
// [R17] conversion done request at rank 13
// [R18] serial receive/transfer share ranks 15, 19
// [R19] ranks 14, 18 refuse macro service
// [R20] vector fetched from per-source table
// [R21] requests latched until accepted or cleared
module ipc_ctrl #(
    parameter int unsigned WDT_BASE = 65536
) (
    input  wire logic                                pclk,                 // system clock
    input  wire logic                                presetn,              // async reset, low
    input  wire logic                                psel,                 // apb select
    input  wire logic                                penable,              // apb enable
    input  wire logic                                pwrite,               // apb direction
    input  wire logic [7:0]                          paddr,                // apb byte address
    input  wire logic [31:0]                         pwdata,               // apb write data
    output logic      [31:0]                         prdata,               // apb read data
    output logic                                     pready,               // apb ready
    output logic                                     pslverr,              // unmapped address
    input  wire logic                                nmi_pin,              // nonmaskable pin
    input  wire logic [5:0]                          ext_edge_req,         // edge request pins
    input  wire ipc_pkg::ipc_tmr_s [ipc_pkg::NTMR-1:0] tmr_in,             // timer count/compare
    input  wire logic                                adc_done_req,         // result moved
    input  wire logic                                uart_a_rx_error_req,  // channel a rx error
    input  wire logic                                uart_a_rx_done_req,   // channel a rx done
    input  wire logic                                sio_a_xfer_done_req,  // channel a clocked done
    input  wire logic                                uart_a_tx_done_req,   // channel a tx done
    input  wire logic                                sync_serial_done_req, // sync serial done
    input  wire logic                                uart_b_rx_error_req,  // channel b rx error
    input  wire logic                                uart_b_rx_done_req,   // channel b rx done
    input  wire logic                                sio_b_xfer_done_req,  // channel b clocked done
    input  wire logic                                uart_b_tx_done_req,   // channel b tx done
    input  wire logic                                break_instruction,    // break executed
    input  wire logic                                cpu_ack,              // cpu takes offer
    input  wire logic                                cpu_return,           // return from handler
    input  wire logic                                macro_done,           // macro transfer ended
    output ipc_pkg::ipc_disp_s                       disp,                 // dispatch offer
    output logic                                     timer1_capture,       // pin 0 edge
    output logic                                     timer2_capture,       // pin 1 edge
    output logic                                     timer2_count,         // pin 2 edge
    output logic      [7:0]                          standby_control_reg   // standby control
);

    // ==================================================================
    // state
    ipc_pkg::ipc_state_s q;
    ipc_pkg::ipc_state_s n;

    function automatic logic [4:0] pin_rank(input int j);
        if (j == 4) return 5'(ipc_pkg::RANK_P4);
        if (j == 5) return 5'(ipc_pkg::RANK_P5);
        return 5'(j);
    endfunction : pin_rank

    logic [ipc_pkg::NFLAG-1:0] set;
    logic [ipc_pkg::NFLAG-1:0] clr;
    logic [ipc_pkg::NPIN-1:0]  rise;
    logic [ipc_pkg::NPIN-1:0]  fall;
    logic                      tick;
    logic                      hit;
    logic                      eq;
    logic                      acc;
    logic                      wr;
    logic [7:0]                pval;
    logic [ipc_pkg::WDT_W-1:0] wlim;
    logic                      best_ok;
    logic [4:0]                best;
    logic [2:0]                cur;
    logic                      nmi_go;
    logic                      use_wdt;
    ipc_pkg::ipc_mode_e        bm;

    always_comb begin
        n       = q;
        set     = '0;
        clr     = '0;
        hit     = 1'b0;
        eq      = 1'b0;
        bm      = ipc_pkg::IPC_VECTOR;
        use_wdt = 1'b0;
        nmi_go  = 1'b0;
        // ==============================================================
        // pin synchronisers and sampled noise filter
        n.s1  = {ext_edge_req, nmi_pin};
        n.s2  = q.s1;
        n.s3  = q.s2;
        n.div = q.div + 6'h01;
        unique case (q.edge_cfg[ipc_pkg::EDGE_SMP +: 2]) // R14
            2'd0: tick = (q.div & ipc_pkg::DIV_M1) == '0;
            2'd1: tick = (q.div & ipc_pkg::DIV_M4) == '0;
            2'd2: tick = (q.div & ipc_pkg::DIV_M16) == '0;
            2'd3: tick = (q.div & ipc_pkg::DIV_M64) == '0;
        endcase
        for (int i = 0; i < ipc_pkg::NPIN; i++) begin
            // pins 0-3 change only on the sample tick
            if (q.s2[i] == q.s3[i] && (i == 0 || i > 4 || tick)) begin // R14
                n.pin[i] = q.s2[i];
            end
        end
        rise = n.pin & ~q.pin;
        fall = ~n.pin & q.pin;
        set[ipc_pkg::SRC_NMI] = q.edge_cfg[ipc_pkg::EDGE_NMI] ? fall[0] : rise[0]; // R13
        for (int j = 0; j < 6; j++) begin
            hit = (q.edge_cfg[2*j] & rise[j+1]) | (q.edge_cfg[2*j+1] & fall[j+1]); // R14
            set[pin_rank(j)] = hit;
            if (j < 3) begin
                n.trig[j] = hit; // R15
            end
        end
        // ==============================================================
        // timer compare and peripheral sources
        for (int t = 0; t < ipc_pkg::NTMR; t++) begin
            eq = q.tw[t] ? (tmr_in[t].count == tmr_in[t].cmp) // R16
                         : (tmr_in[t].count[7:0] == tmr_in[t].cmp[7:0]);
            n.teq[t] = eq;
            set[ipc_pkg::RANK_TMR + t] = eq & ~q.teq[t]; // R16
        end
        set[ipc_pkg::RANK_AD]   = adc_done_req; // R17
        set[ipc_pkg::RANK_SERA] = uart_a_rx_error_req;
        set[ipc_pkg::RANK_SRA]  = uart_a_rx_done_req | sio_a_xfer_done_req; // R18
        set[ipc_pkg::RANK_STA]  = uart_a_tx_done_req;
        set[ipc_pkg::RANK_CSI]  = sync_serial_done_req;
        set[ipc_pkg::RANK_SERB] = uart_b_rx_error_req;
        set[ipc_pkg::RANK_SRB]  = uart_b_rx_done_req | sio_b_xfer_done_req; // R18
        set[ipc_pkg::RANK_STB]  = uart_b_tx_done_req;
        set[ipc_pkg::SRC_BRK]   = break_instruction; // R9
        // ==============================================================
        // runaway watchdog
        wlim = ipc_pkg::WDT_W'(WDT_BASE) << q.watchdog_mode_reg[ipc_pkg::WDM_SEL +: 2];
        if (q.watchdog_mode_reg[ipc_pkg::WDM_EN]) begin
            n.wcnt = q.wcnt + 1'b1;
            if (q.wcnt == wlim - 1'b1) begin
                n.wcnt                = '0;
                set[ipc_pkg::SRC_WDT] = 1'b1; // R10
            end
        end
        // ==============================================================
        // apb slave: one wait state, answer on second access cycle
        acc       = psel & penable;
        n.pready  = acc & ~q.pready;
        n.pslverr = 1'b0;
        wr        = acc & q.pready & pwrite;
        pval      = pwdata[7:0];
        if (n.pready) begin
            n.prdata = '0;
            unique case (paddr)
                ipc_pkg::OFF_PEND:  n.prdata = 32'(q.pend);
                ipc_pkg::OFF_EN:    n.prdata = 32'(q.en);
                ipc_pkg::OFF_LVL0:  n.prdata = q.lvl[15:0];
                ipc_pkg::OFF_LVL1:  n.prdata = 32'(q.lvl[20:16]);
                ipc_pkg::OFF_MODE0: n.prdata = q.mode[15:0];
                ipc_pkg::OFF_MODE1: n.prdata = 32'(q.mode[20:16]);
                ipc_pkg::OFF_EDGE:  n.prdata = 32'(q.edge_cfg);
                ipc_pkg::OFF_WDM:   n.prdata = 32'(q.watchdog_mode_reg);
                ipc_pkg::OFF_STBY:  n.prdata = 32'(q.stby);
                ipc_pkg::OFF_STAT:  n.prdata = 32'({q.st, q.nmi_isr, q.isr});
                ipc_pkg::OFF_BANK:  n.prdata = 32'(q.bank);
                ipc_pkg::OFF_TW:    n.prdata = 32'(q.tw);
                ipc_pkg::OFF_PROT,
                ipc_pkg::OFF_WCLR:  n.prdata = '0;
                default:            n.pslverr = 1'b1;
            endcase
        end else if (!acc) begin
            n.prdata = '0;
        end
        if (wr) begin
            unique case (paddr)
                ipc_pkg::OFF_PEND:  clr = pwdata[ipc_pkg::NFLAG-1:0]; // R21
                ipc_pkg::OFF_EN:    n.en = pwdata[ipc_pkg::NSRC-1:0];
                ipc_pkg::OFF_LVL0:  n.lvl[15:0] = pwdata; // R1
                ipc_pkg::OFF_LVL1:  n.lvl[20:16] = pwdata[9:0]; // R1
                ipc_pkg::OFF_MODE0: n.mode[15:0] = pwdata; // R4
                ipc_pkg::OFF_MODE1: n.mode[20:16] = pwdata[9:0]; // R4
                ipc_pkg::OFF_EDGE:  n.edge_cfg = pwdata[14:0];
                ipc_pkg::OFF_PROT: begin
                    // store only if operand is the complement
                    if ((pval ^ pwdata[ipc_pkg::PROT_OPND +: 8]) != ipc_pkg::OPND_OK) begin
                        set[ipc_pkg::SRC_OPE] = 1'b1; // R8
                    end else if (pwdata[ipc_pkg::PROT_TGT]) begin
                        n.watchdog_mode_reg = pval[3:0];
                        n.watchdog_mode_reg[ipc_pkg::WDM_EN] = q.watchdog_mode_reg[ipc_pkg::WDM_EN] | pval[ipc_pkg::WDM_EN]; // R11
                    end else begin
                        n.stby = pval;
                    end
                end
                ipc_pkg::OFF_WCLR:  n.wcnt = '0;
                ipc_pkg::OFF_BANK:  n.bank = pwdata[11:0];
                ipc_pkg::OFF_TW:    n.tw = pwdata[ipc_pkg::NTMR-1:0];
                default: ;
            endcase
        end
        // ==============================================================
        // arbitration: level first, then fixed rank
        cur = 3'(ipc_pkg::NLVL);
        for (int l = ipc_pkg::NLVL - 1; l >= 0; l--) begin
            if (q.isr[l]) begin
                cur = 3'(l);
            end
        end
        best_ok = 1'b0;
        best    = '0;
        for (int s = ipc_pkg::NSRC - 1; s >= 0; s--) begin
            // lower level wins, ties to lower rank
            if (q.pend[s] && q.en[s] && {1'b0, q.lvl[s]} < cur // R1
                && (!best_ok || q.lvl[s] <= q.lvl[best])) begin // R2
                best_ok = 1'b1;
                best    = 5'(s);
            end
        end
        if (q.mode[best] == 2'(ipc_pkg::IPC_MACRO)
            && best != 5'(ipc_pkg::RANK_SERA) && best != 5'(ipc_pkg::RANK_SERB)) begin   // R19
            bm = ipc_pkg::IPC_MACRO;
        end else if (q.mode[best] == 2'(ipc_pkg::IPC_BANK)) begin
            bm = ipc_pkg::IPC_BANK;
        end
        nmi_go  = !q.nmi_isr && (q.pend[ipc_pkg::SRC_NMI] || q.pend[ipc_pkg::SRC_WDT]);
        use_wdt = q.pend[ipc_pkg::SRC_WDT]
                  && (q.watchdog_mode_reg[ipc_pkg::WDM_PRI] || !q.pend[ipc_pkg::SRC_NMI]);              // R12
        // ==============================================================
        // dispatch sequence toward the cpu
        unique case (q.st)
            ipc_pkg::ST_IDLE: begin
                n.disp      = '0;
                n.disp.mode = ipc_pkg::IPC_VECTOR; // R5
                if (q.pend[ipc_pkg::SRC_OPE]) begin
                    n.disp.src = ipc_pkg::SRC_OPE;
                    n.disp.vec = ipc_pkg::VEC_OPE; // R20
                end else if (q.pend[ipc_pkg::SRC_BRK]) begin
                    n.disp.src = ipc_pkg::SRC_BRK;
                    n.disp.vec = ipc_pkg::VEC_BRK; // R20
                end else if (nmi_go) begin
                    n.disp.src = use_wdt ? ipc_pkg::SRC_WDT : ipc_pkg::SRC_NMI;          // R12
                    n.disp.vec = use_wdt ? ipc_pkg::VEC_WDT : ipc_pkg::VEC_NMI;          // R20
                end else if (best_ok) begin
                    n.disp.src  = best;
                    n.disp.mode = bm; // R4
                    n.disp.vec  = ipc_pkg::VEC_BASE + {10'h000, best, 1'b0}; // R20
                    n.disp.lvl  = q.lvl[best];
                    n.disp.bank = q.bank[q.lvl[best]]; // R6
                end
                n.disp.valid = q.pend[ipc_pkg::SRC_OPE] | q.pend[ipc_pkg::SRC_BRK] | nmi_go | best_ok;
                if (n.disp.valid) begin
                    n.st = ipc_pkg::ST_OFFER;
                end
            end
            ipc_pkg::ST_OFFER: begin
                if (cpu_ack) begin
                    clr[q.disp.src] = 1'b1; // R21
                    n.disp.valid    = 1'b0;
                    if (q.disp.src == ipc_pkg::SRC_NMI || q.disp.src == ipc_pkg::SRC_WDT) begin
                        n.nmi_isr = 1'b1;
                    end
                    if (q.disp.mode == ipc_pkg::IPC_MACRO) begin
                        n.st = ipc_pkg::ST_MACRO; // R7
                    end else begin
                        if (q.disp.src < 5'(ipc_pkg::NSRC)) begin
                            n.isr[q.disp.lvl] = 1'b1; // R1
                        end
                        n.st = ipc_pkg::ST_IDLE;
                    end
                end
            end
            ipc_pkg::ST_MACRO: begin
                // no offer until the transfer ends
                if (macro_done) begin
                    n.st = ipc_pkg::ST_IDLE; // R3
                end
            end
            default: n.st = ipc_pkg::ST_IDLE;
        endcase
        // return ends the most urgent handler
        if (cpu_return) begin
            if (q.nmi_isr) begin
                n.nmi_isr = 1'b0; // R5
            end else if (cur < 3'(ipc_pkg::NLVL)) begin
                n.isr[cur[1:0]] = 1'b0; // R5
            end
        end
        n.pend = (q.pend & ~clr) | set; // R21
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            q <= '0;
        end else begin
            q <= n;
        end
    end

    // ==================================================================
    // outputs straight from state flops
    assign prdata              = q.prdata;
    assign pready              = q.pready;
    assign pslverr             = q.pslverr;
    assign disp                = q.disp;
    assign timer1_capture      = q.trig[0];
    assign timer2_capture      = q.trig[1];
    assign timer2_count        = q.trig[2];
    assign standby_control_reg = q.stby;

endmodule : ipc_ctrl

// [ipc_ctrl_assertions.sv]
`timescale 1ns/10ps
module ipc_ctrl_chk #(parameter int unsigned WDT_BASE = 65536) (
    input wire logic               pclk, presetn, pready, cpu_ack, // clock, reset, ready, ack
    input wire ipc_pkg::ipc_disp_s disp,                           // dispatch offer
    input wire logic [7:0]         standby_control_reg             // standby control
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    // ==================================================================
    // offers, vectors and protected writes
    property p_hold; disp.valid && !cpu_ack |=> $stable(disp); endproperty
    a_hold: assert property (p_hold) else $error("offer changed before ack");
    property p_drop; disp.valid && cpu_ack |=> !disp.valid; endproperty
    a_drop: assert property (p_drop) else $error("offer still up after ack");
    // no fresh offer in the two cycles after a macro offer is taken
    property p_macro; disp.valid && cpu_ack && disp.mode == ipc_pkg::IPC_MACRO |=> !disp.valid [*2]; endproperty
    a_macro: assert property (p_macro) else $error("offer during macro transfer");
    property p_nomac; disp.valid && (disp.src == 5'd14 || disp.src == 5'd18) |-> disp.mode != ipc_pkg::IPC_MACRO;
    endproperty
    a_nomac: assert property (p_nomac) else $error("macro offered for error slot");
    property p_vec; disp.valid && disp.src <= 5'd20 && disp.mode == ipc_pkg::IPC_VECTOR
        |-> disp.vec == ipc_pkg::VEC_BASE + {10'h000, disp.src, 1'b0}; endproperty
    a_vec: assert property (p_vec) else $error("wrong maskable vector");
    property p_sw; disp.valid && (disp.src == ipc_pkg::SRC_OPE || disp.src == ipc_pkg::SRC_BRK)
        |-> disp.mode == ipc_pkg::IPC_VECTOR && disp.vec == (disp.src[0] ? ipc_pkg::VEC_OPE : ipc_pkg::VEC_BRK);
    endproperty
    a_sw: assert property (p_sw) else $error("wrong software vector");
    property p_wdt; disp.valid && disp.src == ipc_pkg::SRC_WDT |-> disp.vec == ipc_pkg::VEC_WDT; endproperty
    a_wdt: assert property (p_wdt) else $error("wrong watchdog vector");
    property p_stby; $changed(standby_control_reg) |-> $past(pready); endproperty
    a_stby: assert property (p_stby) else $error("standby changed outside a write");
    c_macro: cover property (disp.valid && disp.mode == ipc_pkg::IPC_MACRO);
    c_wdt: cover property (disp.valid && disp.src == ipc_pkg::SRC_WDT);
    c_brk: cover property (disp.valid && disp.src == ipc_pkg::SRC_BRK);
endmodule : ipc_ctrl_chk
bind ipc_ctrl ipc_ctrl_chk #(.WDT_BASE(WDT_BASE)) ipc_ctrl_chk_inst (.pclk, .presetn, .pready, .cpu_ack, .disp,
    .standby_control_reg);

// [ipc_cpu_model.sv]
`timescale 1ns/10ps
module ipc_cpu_model (
    input  wire logic               pclk, presetn, slow,             // clock, reset low, long handlers
    input  wire ipc_pkg::ipc_disp_s disp,                            // dispatch offer
    output logic                    cpu_ack, cpu_return, macro_done, // core strobes
    output ipc_pkg::ipc_disp_s      got,                             // last offer taken
    output int                      n_got                            // offers taken
);
    logic [3:0] wait_q;
    logic       busy_q;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            {cpu_ack, cpu_return, macro_done, busy_q, wait_q, got, n_got} <= '0;
        end else begin
            {cpu_ack, cpu_return, macro_done} <= 3'b000;
            if (wait_q != 4'h0) begin
                wait_q <= wait_q - 4'h1;
            end else if (busy_q) begin
                // macro ends by its own strobe, never by a return
                {busy_q, macro_done} <= {1'b0, got.mode == ipc_pkg::IPC_MACRO};
                cpu_return <= got.mode != ipc_pkg::IPC_MACRO;
            end else if (disp.valid) begin
                {cpu_ack, busy_q, got, n_got} <= {2'b11, disp, n_got + 1};
                wait_q <= slow ? 4'h6 : 4'h1;
            end
        end
    end
endmodule : ipc_cpu_model

// [ipc_ctrl_test.sv]
`timescale 1ns/10ps
module ipc_ctrl_test;
    logic               pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, slow = 1'b0, e;
    logic               pready, pslverr, cpu_ack, cpu_return, macro_done, nmi = 1'b0;
    logic [7:0]         paddr = 8'h00, stby, lf = 8'h24;
    logic [31:0]        pwdata = 32'h0, prdata, r;
    logic [5:0]         ext_edge_req = 6'h00;
    logic [10:0]        src_q = 11'h000;
    ipc_pkg::ipc_disp_s disp, got;
    int                 n_got, last = 0, num_errors = 0, n_checks = 0;
    always #2 pclk = ~pclk;
    ipc_ctrl #(.WDT_BASE(16)) ipc_ctrl_inst (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
        .pready, .pslverr, .nmi_pin(nmi), .ext_edge_req, .tmr_in('0), .adc_done_req(src_q[0]),
        .uart_a_rx_error_req(src_q[1]), .uart_a_rx_done_req(src_q[2]), .sio_a_xfer_done_req(src_q[3]),
        .uart_a_tx_done_req(src_q[4]), .sync_serial_done_req(src_q[5]), .uart_b_rx_error_req(src_q[6]),
        .uart_b_rx_done_req(src_q[7]), .sio_b_xfer_done_req(src_q[8]), .uart_b_tx_done_req(src_q[9]),
        .break_instruction(src_q[10]), .cpu_ack, .cpu_return, .macro_done, .disp, .timer1_capture(),
        .timer2_capture(), .timer2_count(), .standby_control_reg(stby));
    ipc_cpu_model ipc_cpu_model_inst (.pclk, .presetn, .slow, .disp, .cpu_ack, .cpu_return, .macro_done, .got, .n_got);
    function automatic logic [7:0] lfsr(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction : lfsr
    task automatic chk(input logic [31:0] a, input logic [31:0] b);
        n_checks++;
        if (a !== b) begin
            num_errors++;
            $display("unexpected at %0t: got %h exp %h", $time, a, b);
        end
    endtask : chk
    task automatic wrap_up(input int tmo);
        num_errors += tmo;
        $display("checks %0d mismatches %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : wrap_up
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int k = 0;
        @(posedge pclk);
        {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1 && ++k < 20);
        if (k >= 20) wrap_up(1);
        {r, e} = {prdata, pslverr};
        {psel, penable} <= 2'b00;
    endtask : apb
    task automatic offer(input logic [4:0] s, input logic [1:0] m, input logic [15:0] v);
        int k = 0;
        while (n_got == last && k++ < 300) @(posedge pclk);
        if (k > 300) wrap_up(1);
        last++;
        // only vectored offers have their branch target checked
        chk({9'h0, got.src, got.mode, got.vec}, {9'h0, s, m, m == 2'd0 ? v : got.vec});
    endtask : offer
    initial begin
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, ipc_pkg::OFF_WDM, 32'h0);
        chk(r, 32'h0);
        apb(1'b0, 8'h3C, 32'h0);
        chk({r[31:1], e}, 32'h1);
        apb(1'b1, ipc_pkg::OFF_EN, 32'h001FFFFF);
        for (int i = 4; i <= 10; i++) offer(i[4:0], 2'd0, 16'h0006 + 16'(2 * i));
        apb(1'b1, ipc_pkg::OFF_LVL0, 32'h04000000);
        apb(1'b1, ipc_pkg::OFF_MODE0, 32'h28000000);
        src_q <= 11'h003;
        @(posedge pclk);
        src_q <= 11'h000;
        offer(5'd14, 2'd0, 16'h0022);
        offer(5'd13, 2'd2, 16'h0020);
        apb(1'b1, ipc_pkg::OFF_LVL0, 32'h0);
        src_q <= 11'h3FC;
        @(posedge pclk);
        src_q <= 11'h000;
        for (int i = 15; i <= 20; i++) offer(i[4:0], 2'd0, 16'h0006 + 16'(2 * i));
        $display("test levels and order done");
        for (int i = 0; i < 3; i++) begin
            lf = lfsr(lf);
            apb(1'b1, ipc_pkg::OFF_PROT, {16'h0, ~lf, lf});
            apb(1'b0, ipc_pkg::OFF_STBY, 32'h0);
            chk(r, {24'h0, lf});
            chk({24'h0, stby}, {24'h0, lf});
            apb(1'b1, ipc_pkg::OFF_PROT, {16'h0, lf, lf});
            offer(ipc_pkg::SRC_OPE, 2'd0, 16'h003C);
        end
        src_q <= 11'h400;
        @(posedge pclk);
        src_q <= 11'h000;
        offer(ipc_pkg::SRC_BRK, 2'd0, 16'h003E);
        apb(1'b1, ipc_pkg::OFF_EDGE, 32'h1);
        {nmi, ext_edge_req} <= 7'h41;
        offer(ipc_pkg::SRC_NMI, 2'd0, 16'h0002);
        offer(5'd0, 2'd0, 16'h0006);
        $display("test software and pin done");
        slow <= 1'b1;
        apb(1'b1, ipc_pkg::OFF_PROT, 32'h0001FE01);
        offer(ipc_pkg::SRC_WDT, 2'd0, 16'h0004);
        apb(1'b1, ipc_pkg::OFF_PROT, 32'h0001FF00);
        apb(1'b0, ipc_pkg::OFF_WDM, 32'h0);
        chk(r, 32'h1);
        $display("test watchdog done");
        wrap_up(0);
    end
endmodule : ipc_ctrl_test
